// ### hdl/iefl_core.sv
`timescale 1ns/1ps
module iefl_core
  import iefl_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Event sources.
  input wire iefl_events_s events,
  input wire logic external_interrupt_pin,
  // Requests.
  output logic core_irq_request,
  output logic irq
);

  // Both addresses of the core control register decode alike.
  function automatic logic is_core_addr(input logic [7:0] a);
    return (a == IEFL_ADDR_CORE_CTL) || (a == IEFL_ADDR_CORE_CTL_MIRROR);
  endfunction

  // Write strobe for one register address.
  function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] r);
    return wr && (a == r);
  endfunction

  iefl_core_ctl_s ctl;
  logic [7:0] periph_en;
  logic [7:0] periph_flag;
  logic edge_sel;
  logic [7:0] evt_status;
  logic [7:0] evt_mask;
  logic [7:0] evt_vec;
  logic [7:0] read_value;
  logic [7:0] next_periph_flag;
  logic pin_level;
  logic ext_edge;
  logic wr_core;
  logic wr_pen;
  logic wr_pflag;
  logic wr_edge;
  logic wr_status;
  logic wr_mask;
  logic core_hit;
  logic periph_hit;
  logic irq_pending;

  // The external pin is asynchronous, so it is synchronised before edge detection.
  iefl_pin_edge u_pin_edge (
    .clk(clk),
    .reset(reset),
    .pin(external_interrupt_pin),
    .rising_sel(edge_sel),
    .level(pin_level),
    .edge_hit(ext_edge)
  );

  // Write decode for every register.
  assign wr_core = reg_wr && is_core_addr(reg_addr);
  assign wr_pen = wr_hit(reg_wr, reg_addr, IEFL_ADDR_PERIPH_EN);
  assign wr_pflag = wr_hit(reg_wr, reg_addr, IEFL_ADDR_PERIPH_FLAG);
  assign wr_edge = wr_hit(reg_wr, reg_addr, IEFL_ADDR_EDGE_CFG);
  assign wr_status = wr_hit(reg_wr, reg_addr, IEFL_ADDR_EVT_STATUS);
  assign wr_mask = wr_hit(reg_wr, reg_addr, IEFL_ADDR_EVT_MASK);

  // Core control register. Hardware sets come after the write, so a flag raised in
  // the same cycle as a software clear survives; losing an event would be worse.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl <= iefl_core_ctl_s'(IEFL_CORE_CTL_RESET);
    end else begin
      if (wr_core) begin
        ctl <= iefl_core_ctl_s'(reg_wdata);
      end
      if (events.timer0_rollover) begin
        ctl.timer0_overflow_flag <= 1'h1;
      end
      if (ext_edge) begin
        ctl.ext_pin_irq_flag <= 1'h1;
      end
      if (events.port_change) begin
        ctl.port_change_flag <= 1'h1;
      end
    end
  end

  // Peripheral enables; unimplemented positions are never stored.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      periph_en <= IEFL_PERIPH_EN_RESET;
    end else if (wr_pen) begin
      periph_en <= reg_wdata & IEFL_PERIPH_IMPL_MASK;
    end
  end

  // Next peripheral flags: software write first, then each event sets its bit.
  always_comb begin
    next_periph_flag = periph_flag;
    if (wr_pflag) begin
      next_periph_flag = reg_wdata & IEFL_PERIPH_IMPL_MASK;
    end
    next_periph_flag[IEFL_PBIT_ADC] = next_periph_flag[IEFL_PBIT_ADC] | events.adc_done;
    next_periph_flag[IEFL_PBIT_SERIAL] =
      next_periph_flag[IEFL_PBIT_SERIAL] | events.serial_done;
    next_periph_flag[IEFL_PBIT_CAPCOMP] =
      next_periph_flag[IEFL_PBIT_CAPCOMP] | events.capcomp_event;
    next_periph_flag[IEFL_PBIT_TIMER2] =
      next_periph_flag[IEFL_PBIT_TIMER2] | events.timer2_match;
    next_periph_flag[IEFL_PBIT_TIMER1] =
      next_periph_flag[IEFL_PBIT_TIMER1] | events.timer1_overflow;
  end

  // Peripheral flags hold until written zero, whatever the enables say.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      periph_flag <= IEFL_PERIPH_FLAG_RESET;
    end else begin
      periph_flag <= next_periph_flag;
    end
  end

  // Edge select for the external pin; the reset value picks the rising edge.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      edge_sel <= IEFL_EDGE_SEL_RESET;
    end else if (wr_edge) begin
      edge_sel <= reg_wdata[IEFL_BIT_EDGE_SEL];
    end
  end

  // Raw event vector in the status layout.
  always_comb begin
    evt_vec = 8'h00;
    evt_vec[IEFL_EV_TIMER0] = events.timer0_rollover;
    evt_vec[IEFL_EV_EXT] = ext_edge;
    evt_vec[IEFL_EV_PORT] = events.port_change;
    evt_vec[IEFL_EV_TIMER1] = events.timer1_overflow;
    evt_vec[IEFL_EV_TIMER2] = events.timer2_match;
    evt_vec[IEFL_EV_CAPCOMP] = events.capcomp_event;
    evt_vec[IEFL_EV_SERIAL] = events.serial_done;
    evt_vec[IEFL_EV_ADC] = events.adc_done;
  end

  // Sticky event status, cleared by writing one; a new event beats the clear.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      evt_status <= IEFL_EVT_STATUS_RESET;
    end else begin
      evt_status <= (evt_status & ~(wr_status ? reg_wdata : 8'h00)) | evt_vec;
    end
  end

  // Event mask, same layout as the status.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      evt_mask <= IEFL_EVT_MASK_RESET;
    end else if (wr_mask) begin
      evt_mask <= reg_wdata;
    end
  end

  // Flag and enable pairs for the two source groups.
  assign core_hit = (ctl.timer0_overflow_flag & ctl.timer0_overflow_enable)
                  | (ctl.ext_pin_irq_flag & ctl.ext_pin_irq_enable)
                  | (ctl.port_change_flag & ctl.port_change_enable);
  assign periph_hit = |(periph_flag & periph_en);

  // Request to the core, registered so the output comes from a flip-flop.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      core_irq_request <= 1'h0;
    end else begin
      core_irq_request <= ctl.global_irq_gate
        & (core_hit | (ctl.peripheral_irq_gate & periph_hit));
    end
  end

  // Unmasked status, one cycle ahead of the interrupt output.
  assign irq_pending = |(evt_status & evt_mask);

  // System interrupt level, one cycle behind the unmasked status.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq <= 1'h0;
    end else begin
      irq <= irq_pending;
    end
  end

  // Read multiplexer; unmapped addresses read zero.
  always_comb begin
    read_value = IEFL_READ_IDLE;
    case (reg_addr)
      IEFL_ADDR_CORE_CTL, IEFL_ADDR_CORE_CTL_MIRROR: begin
        read_value = ctl;
      end
      IEFL_ADDR_PERIPH_EN: begin
        read_value = periph_en & IEFL_PERIPH_IMPL_MASK;
      end
      IEFL_ADDR_PERIPH_FLAG: begin
        read_value = periph_flag & IEFL_PERIPH_IMPL_MASK;
      end
      IEFL_ADDR_EDGE_CFG: begin
        read_value[IEFL_BIT_EDGE_SEL] = edge_sel;
      end
      IEFL_ADDR_EVT_STATUS: begin
        read_value = evt_status;
      end
      IEFL_ADDR_EVT_MASK: begin
        read_value = evt_mask;
      end
      default: begin
        read_value = IEFL_READ_IDLE;
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= IEFL_READ_IDLE;
    end else begin
      reg_rdata <= reg_rd ? read_value : IEFL_READ_IDLE;
    end
  end

  // Checks on the behaviour above.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // A timer0 source that is fully armed.
  sequence s_t0_pending;
    ctl.global_irq_gate && ctl.timer0_overflow_enable && ctl.timer0_overflow_flag;
  endsequence

  // A peripheral source that is fully armed.
  sequence s_periph_pending;
    ctl.global_irq_gate && ctl.peripheral_irq_gate && periph_hit;
  endsequence

  // A read of the peripheral enable register.
  sequence s_pen_read;
    reg_rd && (reg_addr == IEFL_ADDR_PERIPH_EN);
  endsequence

  // A software write that clears the external flag.
  sequence s_ext_clear;
    wr_core && !reg_wdata[IEFL_BIT_EXT_FLAG];
  endsequence

  property p_global_gate_blocks;
    !ctl.global_irq_gate |=> !core_irq_request;
  endproperty
  a_global_gate_blocks: assert property (p_global_gate_blocks)
    else $error("request raised with global gate clear");

  property p_periph_gate_blocks;
    !ctl.peripheral_irq_gate && !core_hit |=> !core_irq_request;
  endproperty
  a_periph_gate_blocks: assert property (p_periph_gate_blocks)
    else $error("peripheral request passed a closed gate");

  property p_t0_request;
    s_t0_pending |=> core_irq_request;
  endproperty
  a_t0_request: assert property (p_t0_request)
    else $error("armed timer0 source gave no request");

  property p_ext_flag_holds;
    ctl.ext_pin_irq_flag && !(wr_core && !reg_wdata[IEFL_BIT_EXT_FLAG])
      |=> ctl.ext_pin_irq_flag;
  endproperty
  a_ext_flag_holds: assert property (p_ext_flag_holds)
    else $error("external flag dropped without a clearing write");

  // A clearing write with no new edge in the same cycle leaves the flag low.
  property p_ext_flag_clear;
    s_ext_clear ##0 !ext_edge |=> !ctl.ext_pin_irq_flag;
  endproperty
  a_ext_flag_clear: assert property (p_ext_flag_clear)
    else $error("external flag survived a clearing write");

  property p_flag_ignores_enable;
    events.timer1_overflow && !ctl.global_irq_gate |=> periph_flag[IEFL_PBIT_TIMER1];
  endproperty
  a_flag_ignores_enable: assert property (p_flag_ignores_enable)
    else $error("timer1 flag not set while gates closed");

  property p_pen_reserved_zero;
    s_pen_read |=> (reg_rdata & ~IEFL_PERIPH_IMPL_MASK) == 8'h00;
  endproperty
  a_pen_reserved_zero: assert property (p_pen_reserved_zero)
    else $error("unimplemented enable bits read nonzero");

  property p_edge_rise;
    edge_sel && $rose(pin_level) |=> ctl.ext_pin_irq_flag;
  endproperty
  a_edge_rise: assert property (p_edge_rise)
    else $error("rising pin edge missed");

  property p_edge_fall;
    !edge_sel && $fell(pin_level) |=> ctl.ext_pin_irq_flag;
  endproperty
  a_edge_fall: assert property (p_edge_fall)
    else $error("falling pin edge missed");

  property p_pflag_holds;
    periph_flag[IEFL_PBIT_TIMER1] && !(wr_pflag && !reg_wdata[IEFL_PBIT_TIMER1])
      |=> periph_flag[IEFL_PBIT_TIMER1];
  endproperty
  a_pflag_holds: assert property (p_pflag_holds)
    else $error("peripheral flag dropped without a clearing write");

  property p_t0_flag_set;
    events.timer0_rollover |=> ctl.timer0_overflow_flag;
  endproperty
  a_t0_flag_set: assert property (p_t0_flag_set)
    else $error("timer0 rollover did not set its flag");

  property p_periph_request;
    s_periph_pending |=> core_irq_request;
  endproperty
  a_periph_request: assert property (p_periph_request)
    else $error("armed peripheral source gave no request");

  property p_irq_follows_status;
    1'b1 |=> (irq == $past(irq_pending));
  endproperty
  a_irq_follows_status: assert property (p_irq_follows_status)
    else $error("interrupt output disagrees with masked status");

endmodule

// ### hdl/iefl_pin_edge.sv
`timescale 1ns/1ps
module iefl_pin_edge (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Pin and chosen edge.
  input wire logic pin,
  input wire logic rising_sel,
  // Synchronised level and edge pulse.
  output logic level,
  output logic edge_hit
);

  logic meta;
  logic prev;

  // Two flip-flops bring the pin into the clock domain; the first feeds only the second.
  // Both reset high so an idle, pulled-up pin shows no edge after reset.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta <= 1'h1;
      level <= 1'h1;
    end else begin
      meta <= pin;
      level <= meta;
    end
  end

  // Previous synchronised level for edge detection.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prev <= 1'h1;
    end else begin
      prev <= level;
    end
  end

  // One-cycle pulse on the selected edge only.
  assign edge_hit = rising_sel ? (level & ~prev) : (~level & prev);

endmodule

// ### hdl/iefl_pkg.sv
package iefl_pkg;

  // Register offsets on the register port.
  localparam logic [7:0] IEFL_ADDR_CORE_CTL = 8'h0B;
  localparam logic [7:0] IEFL_ADDR_CORE_CTL_MIRROR = 8'h8B;
  localparam logic [7:0] IEFL_ADDR_PERIPH_FLAG = 8'h0C;
  localparam logic [7:0] IEFL_ADDR_PERIPH_EN = 8'h8C;
  localparam logic [7:0] IEFL_ADDR_EDGE_CFG = 8'h81;
  localparam logic [7:0] IEFL_ADDR_EVT_STATUS = 8'h90;
  localparam logic [7:0] IEFL_ADDR_EVT_MASK = 8'h91;

  // Field positions in the core interrupt control register.
  localparam int unsigned IEFL_BIT_GLOBAL_GATE = 7;
  localparam int unsigned IEFL_BIT_PERIPH_GATE = 6;
  localparam int unsigned IEFL_BIT_EXT_FLAG = 1;

  // Field positions in the peripheral enable and flag registers.
  localparam int unsigned IEFL_PBIT_ADC = 6;
  localparam int unsigned IEFL_PBIT_SERIAL = 3;
  localparam int unsigned IEFL_PBIT_CAPCOMP = 2;
  localparam int unsigned IEFL_PBIT_TIMER2 = 1;
  localparam int unsigned IEFL_PBIT_TIMER1 = 0;
  localparam logic [7:0] IEFL_PERIPH_IMPL_MASK = 8'h4F;

  // Edge select position in the edge configuration register.
  localparam int unsigned IEFL_BIT_EDGE_SEL = 6;

  // Event status and mask bit positions.
  localparam int unsigned IEFL_EV_TIMER0 = 0;
  localparam int unsigned IEFL_EV_EXT = 1;
  localparam int unsigned IEFL_EV_PORT = 2;
  localparam int unsigned IEFL_EV_TIMER1 = 3;
  localparam int unsigned IEFL_EV_TIMER2 = 4;
  localparam int unsigned IEFL_EV_CAPCOMP = 5;
  localparam int unsigned IEFL_EV_SERIAL = 6;
  localparam int unsigned IEFL_EV_ADC = 7;

  // Reset values.
  localparam logic [7:0] IEFL_CORE_CTL_RESET = 8'h00;
  localparam logic [7:0] IEFL_PERIPH_EN_RESET = 8'h00;
  localparam logic [7:0] IEFL_PERIPH_FLAG_RESET = 8'h00;
  localparam logic IEFL_EDGE_SEL_RESET = 1'h1;
  localparam logic [7:0] IEFL_EVT_STATUS_RESET = 8'h00;
  localparam logic [7:0] IEFL_EVT_MASK_RESET = 8'h00;
  localparam logic [7:0] IEFL_READ_IDLE = 8'h00;

  // Core interrupt control register, bit 7 first.
  typedef struct packed {
    logic global_irq_gate;
    logic peripheral_irq_gate;
    logic timer0_overflow_enable;
    logic ext_pin_irq_enable;
    logic port_change_enable;
    logic timer0_overflow_flag;
    logic ext_pin_irq_flag;
    logic port_change_flag;
  } iefl_core_ctl_s;

  // One-cycle event pulses from on-chip sources on the same clock.
  typedef struct packed {
    logic adc_done;
    logic serial_done;
    logic capcomp_event;
    logic timer2_match;
    logic timer1_overflow;
    logic timer0_rollover;
    logic port_change;
  } iefl_events_s;

endpackage

// ### test/iefl_src_model.sv
`timescale 1ns/1ps
module iefl_src_model
  import iefl_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Event pulses and external pin toward the block.
  output iefl_events_s events,
  output logic pin
);
  // Requests from the tasks; sources idle low, the pin idles high as if pulled up.
  logic [6:0] fire = 7'h00;
  logic level = 1'b1;

  // One clocked process alone drives the outputs, one edge after each request.
  always @(posedge clk) begin
    events <= iefl_events_s'(fire);
    pin <= level;
  end

  // One-cycle pulse on one source, requested just after an edge and dropped after the next.
  task automatic pulse(input int idx);
    logic [6:0] v;
    v = 7'h00;
    v[idx] = 1'b1;
    @(posedge clk);
    fire <= v;
    @(posedge clk);
    fire <= 7'h00;
  endtask

  // New pin level, held long enough for the two-flop synchroniser and edge detector.
  task automatic drive_pin(input logic lvl);
    @(posedge clk);
    level <= lvl;
    repeat (5) @(posedge clk);
  endtask
endmodule

// ### test/interrupt_enable_flag_logic_tb.sv
`timescale 1ns/1ps
module interrupt_enable_flag_logic_tb;
  import iefl_pkg::*;
  logic clk;
  logic reset;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  iefl_events_s events;
  logic pin;
  logic core_irq_request;
  logic irq;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  // Core sources: enable and flag pairs; peripheral bits and their event indices.
  logic [7:0] core_bits [3] = '{8'h24, 8'h12, 8'h09};
  logic [7:0] pbits [5] = '{8'h40, 8'h08, 8'h04, 8'h02, 8'h01};
  int pev [5] = '{6, 5, 4, 3, 2};

  iefl_core uut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .events(events),
    .external_interrupt_pin(pin), .core_irq_request(core_irq_request), .irq(irq));
  iefl_src_model src (.clk(clk), .events(events), .pin(pin));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard: the whole sequence needs well under a thousand cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe edge, so it is taken there.
  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    n_checks++;
    if (reg_rdata !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, reg_rdata);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Requests are registered one cycle behind the flag or register they follow.
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rdchk("core_reset", IEFL_ADDR_CORE_CTL, IEFL_CORE_CTL_RESET);
    rdchk("pen_reset", IEFL_ADDR_PERIPH_EN, 8'h00);
    rdchk("edge_reset", IEFL_ADDR_EDGE_CFG, 8'h40);
    chk1("req_reset", 1'b0, core_irq_request);
    $display("test reset values done");

    wr(IEFL_ADDR_PERIPH_EN, 8'hFF);
    rdchk("pen_impl", IEFL_ADDR_PERIPH_EN, 8'h4F);
    wr(8'h55, 8'hFF);
    rdchk("unmapped", 8'h55, 8'h00);
    wr(IEFL_ADDR_PERIPH_EN, 8'h00);
    $display("test register map done");

    // Timer0, external pin (rising edge by default), port change.
    for (int i = 0; i < 3; i++) begin
      wr(IEFL_ADDR_CORE_CTL, 8'h00);
      if (i == 0)
        src.pulse(1);
      else if (i == 2)
        src.pulse(0);
      else begin
        src.drive_pin(1'b0);
        src.drive_pin(1'b1);
      end
      settle();
      rdchk("core_flag", IEFL_ADDR_CORE_CTL, core_bits[i] & 8'h07);
      chk1("req_no_gate", 1'b0, core_irq_request);
      wr(IEFL_ADDR_CORE_CTL_MIRROR, core_bits[i] | 8'h80);
      settle();
      chk1("req_core", 1'b1, core_irq_request);
      wr(IEFL_ADDR_CORE_CTL, core_bits[i]);
      settle();
      chk1("req_gate_off", 1'b0, core_irq_request);
      rdchk("core_held", IEFL_ADDR_CORE_CTL, core_bits[i]);
    end
    $display("test core sources done");

    // Falling edge select: falling sets the flag, rising does not.
    wr(IEFL_ADDR_CORE_CTL, 8'h00);
    wr(IEFL_ADDR_EDGE_CFG, 8'h00);
    src.drive_pin(1'b0);
    rdchk("ext_falling", IEFL_ADDR_CORE_CTL, 8'h02);
    wr(IEFL_ADDR_CORE_CTL, 8'h00);
    src.drive_pin(1'b1);
    rdchk("ext_rising_ignored", IEFL_ADDR_CORE_CTL, 8'h00);
    $display("test edge select done");

    for (int i = 0; i < 5; i++) begin
      wr(IEFL_ADDR_PERIPH_FLAG, 8'h00);
      wr(IEFL_ADDR_PERIPH_EN, pbits[i]);
      wr(IEFL_ADDR_CORE_CTL, 8'h80);
      src.pulse(pev[i]);
      settle();
      rdchk("pflag", IEFL_ADDR_PERIPH_FLAG, pbits[i]);
      chk1("req_no_pgate", 1'b0, core_irq_request);
      wr(IEFL_ADDR_CORE_CTL, 8'hC0);
      settle();
      chk1("req_pgate", 1'b1, core_irq_request);
      rdchk("pflag_held", IEFL_ADDR_PERIPH_FLAG, pbits[i]);
      wr(IEFL_ADDR_PERIPH_FLAG, 8'h00);
      settle();
      chk1("req_pclear", 1'b0, core_irq_request);
    end
    wr(IEFL_ADDR_PERIPH_EN, 8'h00);
    $display("test peripheral sources done");

    // Status accumulated from earlier tests is cleared first.
    wr(IEFL_ADDR_EVT_STATUS, 8'hFF);
    wr(IEFL_ADDR_EVT_MASK, 8'h00);
    wr(IEFL_ADDR_CORE_CTL, 8'h00);
    src.pulse(2);
    settle();
    rdchk("status", IEFL_ADDR_EVT_STATUS, 8'h08);
    chk1("irq_masked", 1'b0, irq);
    wr(IEFL_ADDR_EVT_MASK, 8'h08);
    settle();
    chk1("irq_on", 1'b1, irq);
    wr(IEFL_ADDR_EVT_STATUS, 8'h08);
    settle();
    chk1("irq_cleared", 1'b0, irq);
    rdchk("status_clear", IEFL_ADDR_EVT_STATUS, 8'h00);
    $display("test event status done");
    complete_run();
  end
endmodule
